/* File: hw/srap_serial_port.sv */
// serial register access port: two-wire or three-wire slave
`timescale 1ns/1ps
`include "srap_regs.svh"
// How it works
// - protocol select input, low picks two-wire
// - port silent until startup load done
// - two-wire address register, resets to 0x09
// - one or two offset bytes, both protocols
// - two-wire short offset: page gives high byte
// - two-wire page register at offset 0xFC
// - two-wire long offset: sixteen bits, high first
// - pointer steps once per data byte
// - slew follows the bus speed field
// - read follows offset write and restart
// - bytes go to ascending addresses, low first
// - spi uses one shared bidirectional data pin
// - spi reads may lead with dummy bytes
// - first spi bit is read/write direction
// - dummy bytes send zeros before data
// - spi short offset: page gives upper nine
// - spi page register at offset 0x7C
// - spi long offset: top address bit zero
// - page register holds little-endian base
// - sampling edge and output timing selectable
module srap_serial_port (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // serial pins
  input wire logic scl_sclk_i,
  input wire logic sda_sdio_i,
  output logic sda_sdio_o,
  output logic sda_sdio_oe_o,
  input wire logic chip_select_pin_n_i,
  // configuration
  input wire logic load_done_i,
  input wire logic ssi_spi_i,
  input wire logic addr_2b_i,
  input wire logic [6:0] i2c_addr_i,
  input wire logic i2c_addr_ovr_i,
  input wire logic [1:0] i2c_speed_i,
  input wire logic spi_dummy_en_i,
  input wire logic [1:0] spi_dummy_size_i,
  input wire logic spi_clk_sel_i,
  input wire logic spi_del_out_i,
  // internal register space
  output srap_pkg::srap_addr_t reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  // status
  output logic [1:0] i2c_slew_o,
  output logic port_ready_o
);
  import srap_pkg::*;

  srap_sys_s q;
  srap_sys_s d;
  srap_link_if lnk ();

  logic rise;
  logic fall;
  logic sda_s;
  logic start;
  logic stop;
  logic ev_hdr;
  logic ev_wr;
  logic ev_tak;
  logic acc_go;
  logic acc_wr;
  srap_addr_t acc_off;
  logic [7:0] acc_dat;
  logic pg_hit;
  logic [4:0] pidx;
  srap_addr_t spi_off;

  // effective register address from offset and page
  function automatic srap_addr_t eff_addr(
    input logic spi,
    input logic b2,
    input srap_addr_t off,
    input logic [31:0] pg
  );
    srap_addr_t a;
    if (b2) begin
      a = spi ? {1'b0, off[14:0]} : off;
    end else begin
      a = spi ? {pg[15:7], off[6:0]} : {pg[15:8], off[7:0]};
    end
    return a;
  endfunction : eff_addr

  // spi frame logic on its own clock
  srap_spi_link u_link (
    .sclk_i(scl_sclk_i),
    .cs_n_i(chip_select_pin_n_i),
    .sdio_i(sda_sdio_i),
    .clk_sel_i(spi_clk_sel_i),
    .del_out_i(spi_del_out_i),
    .lnk(lnk.link)
  );

  // configuration and holding data seen by the link
  assign lnk.hold = q.hold;
  assign lnk.addr_2b = addr_2b_i;
  assign lnk.dum_en = spi_dummy_en_i;
  assign lnk.dum_size = spi_dummy_size_i;
  assign lnk.active = q.ready && ssi_spi_i;
  assign lnk.rst_n = rstn_i;

  // edges of the synchronised pins and link toggles
  assign rise = q.sy2[`SRAP_SY_SCL] && !q.sy3[`SRAP_SY_SCL];
  assign fall = !q.sy2[`SRAP_SY_SCL] && q.sy3[`SRAP_SY_SCL];
  assign sda_s = q.sy2[`SRAP_SY_SDA];
  assign start = q.sy2[`SRAP_SY_SCL] && q.sy3[`SRAP_SY_SCL]
    && !sda_s && q.sy3[`SRAP_SY_SDA];
  assign stop = q.sy2[`SRAP_SY_SCL] && q.sy3[`SRAP_SY_SCL]
    && sda_s && !q.sy3[`SRAP_SY_SDA];
  assign ev_hdr = q.sy2[`SRAP_SY_HDR] ^ q.sy3[`SRAP_SY_HDR];
  assign ev_wr = q.sy2[`SRAP_SY_WR] ^ q.sy3[`SRAP_SY_WR];
  assign ev_tak = q.sy2[`SRAP_SY_TAK] ^ q.sy3[`SRAP_SY_TAK];

  // spi header offset, short or long form
  assign spi_off = addr_2b_i ? {1'b0, lnk.cmd[6:0], lnk.lo}
    : {9'h000, lnk.cmd[6:0]};

  // next state of the system side
  always_comb begin
    d = q;
    acc_go = 1'b0;
    acc_wr = 1'b0;
    acc_off = q.off;
    acc_dat = q.sh;
    pg_hit = 1'b0;
    pidx = 5'h00;
    // two flip-flop synchronisers, stage one read only by stage two
    d.sy1 = {lnk.take_t, lnk.wr_t, lnk.hdr_t, sda_sdio_i, scl_sclk_i};
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    d.reg_wr = 1'b0;
    d.reg_rd = 1'b0;
    d.ready = load_done_i;
    d.slew = i2c_speed_i;
    if (i2c_addr_ovr_i) begin
      d.dev = i2c_addr_i;
    end
    // register read data arrives with the read strobe
    if (q.reg_rd) begin
      d.hold = reg_rdata_i;
    end

    if (!q.ready || ssi_spi_i) begin
      // two-wire slave parked and off the bus
      d.ist = srap_i_idle;
      d.sda_oe = 1'b0;
      d.ackph = 1'b0;
      if (q.ready) begin
        // spi events from the link domain
        if (ev_hdr) begin
          if (lnk.cmd[`SRAP_RW_BIT]) begin
            acc_go = 1'b1;
            acc_off = spi_off;
          end else begin
            d.off = spi_off;
          end
        end else if (ev_wr) begin
          acc_go = 1'b1;
          acc_wr = 1'b1;
          acc_dat = lnk.wb;
        end else if (ev_tak) begin
          acc_go = 1'b1;
        end
      end
    end else if (stop) begin
      d.ist = srap_i_idle;
      d.sda_oe = 1'b0;
      d.ackph = 1'b0;
    end else if (start) begin
      // start or repeated start keeps the pointer
      d.ist = srap_i_dev;
      d.cnt = 4'h0;
      d.ackph = 1'b0;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.ist)
        srap_i_idle, srap_i_skip: begin
          d.sda_oe = 1'b0;
        end
        srap_i_dev, srap_i_rx: begin
          if (rise && !q.ackph && q.cnt != `SRAP_BITS_BYTE) begin
            d.sh = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 4'h1;
          end
          if (fall && q.ackph) begin
            // end of our acknowledge bit
            d.ackph = 1'b0;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
          end else if (fall && q.cnt == `SRAP_BITS_BYTE) begin
            d.ackph = 1'b1;
            if (q.ist == srap_i_dev) begin
              if (q.sh[7:1] == q.dev) begin
                d.sda_oe = 1'b1;
                d.bidx = `SRAP_BI_OFF0;
                if (q.sh[0]) begin
                  d.ist = srap_i_tx;
                  acc_go = 1'b1;
                end else begin
                  d.ist = srap_i_rx;
                end
              end else begin
                d.ist = srap_i_skip;
              end
            end else begin
              d.sda_oe = 1'b1;
              unique case (q.bidx)
                `SRAP_BI_OFF0: begin
                  if (addr_2b_i) begin
                    d.off = {q.sh, q.off[7:0]};
                    d.bidx = `SRAP_BI_OFF1;
                  end else begin
                    d.off = {8'h00, q.sh};
                    d.bidx = `SRAP_BI_DATA;
                  end
                end
                `SRAP_BI_OFF1: begin
                  d.off = {q.off[15:8], q.sh};
                  d.bidx = `SRAP_BI_DATA;
                end
                default: begin
                  acc_go = 1'b1;
                  acc_wr = 1'b1;
                end
              endcase
            end
          end
        end
        srap_i_tx: begin
          if (rise && q.ackph && sda_s) begin
            d.ist = srap_i_skip; // master refused more data
          end else if (rise && !q.ackph && q.cnt != `SRAP_BITS_BYTE) begin
            d.cnt = q.cnt + 4'h1;
          end
          if (fall && q.ackph) begin
            // load next byte and prefetch the one after
            d.ackph = 1'b0;
            d.cnt = 4'h0;
            d.sh = q.hold;
            d.sda_oe = !q.hold[7];
            acc_go = 1'b1;
          end else if (fall && q.cnt == `SRAP_BITS_BYTE) begin
            d.ackph = 1'b1;
            d.sda_oe = 1'b0;
          end else if (fall && q.cnt != 4'h0) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = !q.sh[6];
          end
        end
        default: begin
          d.ist = srap_i_idle;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // one register access per byte, page window intercepted
    if (acc_go) begin
      if (ssi_spi_i) begin
        pg_hit = (acc_off[6:0] & `SRAP_SPI_PAGE_MASK) == `SRAP_SPI_PAGE_MASK;
      end else begin
        pg_hit = (acc_off[7:0] & `SRAP_I2C_PAGE_MASK) == `SRAP_I2C_PAGE_MASK;
      end
      pg_hit = pg_hit && !addr_2b_i;
      pidx = {acc_off[1:0], 3'h0};
      d.off = acc_off + 16'h0001;
      if (acc_wr && pg_hit) begin
        if (ssi_spi_i) begin
          d.pg_s[pidx +: 8] = acc_dat;
        end else begin
          d.pg_i[pidx +: 8] = acc_dat;
        end
      end else if (pg_hit) begin
        d.hold = ssi_spi_i ? q.pg_s[pidx +: 8] : q.pg_i[pidx +: 8];
      end else begin
        d.reg_addr = eff_addr(ssi_spi_i, addr_2b_i, acc_off,
          ssi_spi_i ? q.pg_s : q.pg_i);
        d.reg_wdata = acc_dat;
        d.reg_wr = acc_wr;
        d.reg_rd = !acc_wr;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.dev <= `SRAP_I2C_ADDR_RST;
      q.pg_i <= `SRAP_PG_RST;
      q.pg_s <= `SRAP_PG_RST;
    end else begin
      q <= d;
    end
  end

  // pin drive: open-drain low for two-wire, link data for spi
  assign sda_sdio_o = ssi_spi_i ? lnk.sdo : 1'b0;
  assign sda_sdio_oe_o = ssi_spi_i ? lnk.oe : q.sda_oe;

  // register space and status outputs
  assign reg_addr_o = q.reg_addr;
  assign reg_wdata_o = q.reg_wdata;
  assign reg_wr_o = q.reg_wr;
  assign reg_rd_o = q.reg_rd;
  assign i2c_slew_o = q.slew;
  assign port_ready_o = q.ready;
endmodule : srap_serial_port

/* File: inc/srap_regs.svh */
// constants of the serial register access port
`ifndef SRAP_REGS_SVH
`define SRAP_REGS_SVH
// two-wire slave address after reset
`define SRAP_I2C_ADDR_RST 7'h09
// page register windows in single-byte offset mode
`define SRAP_I2C_PAGE_MASK 8'hFC
`define SRAP_SPI_PAGE_MASK 7'h7C
// page register value after reset
`define SRAP_PG_RST 32'h0000_0000
// bit counting within a byte
`define SRAP_BITS_BYTE 4'h8
`define SRAP_BC_LAST 3'h7
// direction bit of the spi command byte
`define SRAP_RW_BIT 7
// offset byte sequencing of the two-wire write
`define SRAP_BI_OFF0 2'h0
`define SRAP_BI_OFF1 2'h1
`define SRAP_BI_DATA 2'h2
// positions in the synchroniser vector
`define SRAP_SY_SCL 0
`define SRAP_SY_SDA 1
`define SRAP_SY_HDR 2
`define SRAP_SY_WR 3
`define SRAP_SY_TAK 4
`define SRAP_SY_W 5
`endif

/* File: inc/srap_pkg.sv */
// types of the serial register access port
package srap_pkg;
  `include "srap_regs.svh"

  typedef logic [15:0] srap_addr_t;

  // two-wire slave states, gray along idle-dev-rx-tx
  typedef enum logic [2:0] {
    srap_i_idle = 3'h0,
    srap_i_dev = 3'h1,
    srap_i_rx = 3'h3,
    srap_i_tx = 3'h2,
    srap_i_skip = 3'h6
  } srap_i2c_e;

  // spi frame phases, gray along cmd-adr-dum-dat
  typedef enum logic [1:0] {
    srap_l_cmd = 2'h0,
    srap_l_adr = 2'h1,
    srap_l_dum = 2'h3,
    srap_l_dat = 2'h2
  } srap_link_e;

  // spi frame state, cleared by chip select
  typedef struct packed {
    srap_link_e ph;
    logic [2:0] bc;
    logic [1:0] dn;
    logic rd;
    logic [6:0] sh;
    logic oe;
  } srap_link_s;

  // spi captured bytes and event toggles, kept across frames
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] lo;
    logic [7:0] wb;
    logic hdr_t;
    logic wr_t;
    logic take_t;
  } srap_evt_s;

  // system domain state
  typedef struct packed {
    logic [`SRAP_SY_W-1:0] sy1;
    logic [`SRAP_SY_W-1:0] sy2;
    logic [`SRAP_SY_W-1:0] sy3;
    srap_i2c_e ist;
    logic [3:0] cnt;
    logic ackph;
    logic [7:0] sh;
    logic sda_oe;
    logic [1:0] bidx;
    srap_addr_t off;
    logic [7:0] hold;
    logic [31:0] pg_i;
    logic [31:0] pg_s;
    logic [6:0] dev;
    logic [1:0] slew;
    logic ready;
    srap_addr_t reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
  } srap_sys_s;
endpackage : srap_pkg

/* File: inc/srap_link_if.sv */
// signals between the spi link logic and the system side
`timescale 1ns/1ps
interface srap_link_if;
  logic [7:0] cmd;
  logic [7:0] lo;
  logic [7:0] wb;
  logic [7:0] hold;
  logic hdr_t;
  logic wr_t;
  logic take_t;
  logic sdo;
  logic oe;
  logic addr_2b;
  logic dum_en;
  logic [1:0] dum_size;
  logic active;
  logic rst_n;

  modport link (
    output cmd, lo, wb, hdr_t, wr_t, take_t, sdo, oe,
    input hold, addr_2b, dum_en, dum_size, active, rst_n
  );
  modport sys (
    input cmd, lo, wb, hdr_t, wr_t, take_t, sdo, oe,
    output hold, addr_2b, dum_en, dum_size, active, rst_n
  );
endinterface : srap_link_if

/* File: hw/srap_spi_link.sv */
// three-wire spi frame logic on the link clock
`timescale 1ns/1ps
`include "srap_regs.svh"
module srap_spi_link (
  // link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  // static configuration
  input wire logic clk_sel_i,
  input wire logic del_out_i,
  // system side
  srap_link_if.link lnk
);
  import srap_pkg::*;

  srap_link_s q;
  srap_link_s d;
  srap_evt_s eq;
  srap_evt_s ed;
  logic lclk;
  logic [7:0] in_byte;
  logic last;
  logic rd_now;
  logic cur;
  logic sdo_n_q;

  // sampling edge chosen by configuration
  assign lclk = sclk_i ^ clk_sel_i;

  // frame decode, one bit per sampling edge
  always_comb begin
    d = q;
    ed = eq;
    in_byte = {q.sh, sdio_i};
    last = (q.bc == `SRAP_BC_LAST);
    rd_now = (q.ph == srap_l_cmd) ? in_byte[`SRAP_RW_BIT] : q.rd;
    d.bc = q.bc + 3'h1;
    d.sh = in_byte[6:0];
    if (last) begin
      unique case (q.ph)
        srap_l_cmd: begin
          ed.cmd = in_byte;
          d.rd = rd_now;
          if (lnk.addr_2b) begin
            d.ph = srap_l_adr;
          end
        end
        srap_l_adr: ed.lo = in_byte;
        srap_l_dum: begin
          if (q.dn == 2'h0) begin
            d.ph = srap_l_dat;
          end
          d.dn = q.dn - 2'h1;
        end
        srap_l_dat: begin
          if (q.rd) begin
            ed.take_t = ~eq.take_t;
          end else begin
            ed.wb = in_byte;
            ed.wr_t = ~eq.wr_t;
          end
        end
      endcase
    end
    // header complete: dummies only on reads
    if (last && (q.ph == srap_l_adr || (q.ph == srap_l_cmd && !lnk.addr_2b))) begin
      ed.hdr_t = ~eq.hdr_t;
      d.oe = rd_now;
      d.dn = lnk.dum_size;
      d.ph = (rd_now && lnk.dum_en) ? srap_l_dum : srap_l_dat;
    end
    if (!lnk.active) begin
      d = q;
      ed = eq;
    end
  end

  // frame state ends with chip select
  always_ff @(posedge lclk or posedge cs_n_i) begin
    if (cs_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // events survive frames, cleared by system reset
  always_ff @(posedge lclk or negedge lnk.rst_n) begin
    if (!lnk.rst_n) begin
      eq <= '0;
    end else begin
      eq <= ed;
    end
  end

  // read data bit, zero during dummy bytes
  assign cur = (q.ph == srap_l_dat && q.rd) ? lnk.hold[~q.bc] : 1'b0;

  // launch half a bit later unless early output chosen
  always_ff @(negedge lclk or posedge cs_n_i) begin
    if (cs_n_i) begin
      sdo_n_q <= 1'b0;
    end else begin
      sdo_n_q <= cur;
    end
  end

  // link outputs; first bit of a byte taken live so the gap refill reaches it
  assign lnk.sdo = (del_out_i || q.bc == '0) ? cur : sdo_n_q;
  assign lnk.oe = q.oe;
  assign lnk.cmd = eq.cmd;
  assign lnk.lo = eq.lo;
  assign lnk.wb = eq.wb;
  assign lnk.hdr_t = eq.hdr_t;
  assign lnk.wr_t = eq.wr_t;
  assign lnk.take_t = eq.take_t;
endmodule : srap_spi_link

/* File: testbench/srap_serial_port_properties.sv */
// assertion checker for the serial register access port
`timescale 1ns/1ps
module srap_props (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // pins and configuration
  input wire logic chip_select_pin_n_i,
  input wire logic load_done_i,
  input wire logic ssi_spi_i,
  input wire logic addr_2b_i,
  input wire logic [1:0] i2c_speed_i,
  input wire logic sda_sdio_o,
  input wire logic sda_sdio_oe_o,
  // register side and status
  input wire srap_pkg::srap_addr_t reg_addr_o,
  input wire logic [7:0] reg_wdata_o,
  input wire logic reg_wr_o,
  input wire logic reg_rd_o,
  input wire logic [1:0] i2c_slew_o,
  input wire logic port_ready_o
);
  import srap_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // nothing moves before the port is ready
  a_port_dead: assert property (!port_ready_o |-> !reg_wr_o && !reg_rd_o && !sda_sdio_oe_o)
    else $error("port active before ready");
  a_ready_rise: assert property ($rose(load_done_i) |-> ##1 port_ready_o)
    else $error("ready late");
  a_slew_copy: assert property ($past(rstn_i) |-> i2c_slew_o == $past(i2c_speed_i))
    else $error("slew not following speed");
  // one access per serial byte, data standing meanwhile
  a_wr_space: assert property (reg_wr_o |=> (!reg_wr_o && $stable(reg_wdata_o))[*4])
    else $error("write pulse too close");
  a_rd_space: assert property (reg_rd_o |=> (!reg_rd_o && !reg_wr_o)[*4])
    else $error("read pulse too close");
  a_spi_top0: assert property (ssi_spi_i && addr_2b_i && (reg_wr_o || reg_rd_o)
    |-> !reg_addr_o[15])
    else $error("long spi address top bit set");
  // pin discipline per protocol
  a_i2c_od: assert property (!ssi_spi_i |-> !sda_sdio_o)
    else $error("two-wire data driven high");
  a_spi_idle: assert property (ssi_spi_i && chip_select_pin_n_i |-> !sda_sdio_oe_o)
    else $error("spi drives while deselected");
endmodule : srap_props
bind srap_serial_port srap_props u_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .chip_select_pin_n_i(chip_select_pin_n_i), .load_done_i(load_done_i),
  .ssi_spi_i(ssi_spi_i), .addr_2b_i(addr_2b_i), .i2c_speed_i(i2c_speed_i),
  .sda_sdio_o(sda_sdio_o), .sda_sdio_oe_o(sda_sdio_oe_o), .reg_addr_o(reg_addr_o),
  .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
  .i2c_slew_o(i2c_slew_o), .port_ready_o(port_ready_o));

/* File: testbench/srap_host.sv */
// host model driving the shared serial pins
`timescale 1ns/1ps
module srap_host (
  // resolved data line
  input wire logic line_i,
  // pins
  output logic scl_o,
  output logic sda_o,
  output logic sda_en_o,
  output logic cs_n_o
);
  localparam int H = 500; // quarter of a two-wire bit
  // idle bus, spi deselected
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    sda_en_o = 1'b1;
    cs_n_o = 1'b1;
  end
  // one two-wire bit: change in low phase, sample in high phase
  task automatic i2c_bit(input logic d, output logic s);
    #H sda_o = d;
    #H scl_o = 1'b1;
    #H s = line_i;
    #H scl_o = 1'b0;
  endtask : i2c_bit
  // start or repeated start
  task automatic i2c_start();
    #H sda_o = 1'b1;
    #H scl_o = 1'b1;
    #(2*H) sda_o = 1'b0;
    #(2*H) scl_o = 1'b0;
  endtask : i2c_start
  task automatic i2c_stop();
    #H sda_o = 1'b0;
    #H scl_o = 1'b1;
    #(2*H) sda_o = 1'b1;
    #(2*H);
  endtask : i2c_stop
  // byte out, then the acknowledge level
  task automatic i2c_wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], s);
    i2c_bit(1'b1, ack);
  endtask : i2c_wr
  // byte in; last ends the read with a nack
  task automatic i2c_rd(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, b[i]);
    i2c_bit(last, s);
  endtask : i2c_rd
  // spi byte at link rate, msb first, gap after for the refill
  task automatic spi_byte(input logic drv, input logic [7:0] b, output logic [7:0] r);
    sda_en_o = drv;
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      #3 r[i] = line_i;
      scl_o = !scl_o;
      #3 scl_o = !scl_o;
    end
    #800;
  endtask : spi_byte
endmodule : srap_host

/* File: testbench/tb_serial_register_access_port.sv */
// testbench for the serial register access port
`timescale 1ns/1ps
module tb_serial_register_access_port;
  import srap_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b1;
  logic clk_sel, del_out;
  logic load_done, ssi_spi, addr_2b, addr_ovr, dum_en, wr, rd, ready, d_o, d_oe;
  logic scl, h_sda, h_en, cs_n, sda_line;
  logic flt = 1'b0;
  logic [6:0] i2c_addr;
  logic [1:0] speed, dum_size, slew;
  logic [7:0] wdata, rdata;
  srap_addr_t r_addr;
  logic [23:0] wq [$];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  // wired-and in two-wire mode, float pattern on an undriven spi line
  assign sda_line = ssi_spi ? (d_oe ? d_o : (h_en ? h_sda : flt)) : (h_sda & !d_oe);
  srap_serial_port dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .scl_sclk_i(scl),
    .sda_sdio_i(sda_line), .sda_sdio_o(d_o), .sda_sdio_oe_o(d_oe),
    .chip_select_pin_n_i(cs_n), .load_done_i(load_done), .ssi_spi_i(ssi_spi),
    .addr_2b_i(addr_2b), .i2c_addr_i(i2c_addr), .i2c_addr_ovr_i(addr_ovr),
    .i2c_speed_i(speed), .spi_dummy_en_i(dum_en), .spi_dummy_size_i(dum_size),
    .spi_clk_sel_i(clk_sel), .spi_del_out_i(del_out), .reg_addr_o(r_addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata),
    .i2c_slew_o(slew), .port_ready_o(ready));
  srap_host host (.line_i(sda_line), .scl_o(scl), .sda_o(h_sda), .sda_en_o(h_en),
    .cs_n_o(cs_n));
  // register space: read data is a pattern of the address
  function automatic logic [7:0] pat(input srap_addr_t a);
    return {a[0], a[7:1]} ^ a[15:8] ^ 8'h5A;
  endfunction : pat
  assign rdata = pat(r_addr);
  always @(posedge clk_sys_i) if (wr) wq.push_back({r_addr, wdata});
  // clock, float pattern and hang limit
  initial forever #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    flt <= ~flt;
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  // pop the oldest logged write
  task automatic wchk(input logic [23:0] exp);
    chk(wq.size() ? 32'(wq.pop_front()) : 32'hFFFF_FFFF, 32'(exp));
  endtask : wchk
  // two-wire write frame; later bytes must all be acknowledged
  task automatic i2c_burst(input logic [7:0] b [$], input logic ack0, input logic stp);
    logic a;
    @(negedge clk_sys_i);
    host.i2c_start();
    foreach (b[i]) begin
      host.i2c_wr(b[i], a);
      chk(a, i ? 1'b0 : ack0);
    end
    if (stp) host.i2c_stop();
  endtask : i2c_burst
  // spi frame; bytes from nhdr on are left to the device
  task automatic spi_frame(input logic [7:0] b [$], input int nhdr, output logic [7:0] r [$]);
    logic [7:0] x;
    r = {};
    host.cs_n_o = 1'b0;
    #100;
    foreach (b[i]) begin
      host.spi_byte(i < nhdr, b[i], x);
      r.push_back(x);
    end
    host.cs_n_o = 1'b1;
    #300;
  endtask : spi_frame
  task automatic t_dead();
    @(negedge clk_sys_i);
    chk(ready, 1'b0);
    chk(slew, speed);
    i2c_burst('{8'h12}, 1'b1, 1'b1);
    @(negedge clk_sys_i) load_done = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk(ready, 1'b1);
  endtask : t_dead
  task automatic t_i2c_1b();
    i2c_burst('{8'h12, 8'hFC, 8'h00, 8'h01, 8'h00, 8'h00}, 1'b0, 1'b1);
    i2c_burst('{8'h12, 8'h68, 8'h03, 8'h80}, 1'b0, 1'b1);
    wchk(24'h0168_03);
    wchk(24'h0169_80);
    chk(wq.size(), 0);
  endtask : t_i2c_1b
  task automatic t_i2c_rd();
    logic a;
    logic [7:0] d0, d1;
    @(negedge clk_sys_i) addr_2b = 1'b1;
    i2c_burst('{8'h12, 8'h01, 8'h68}, 1'b0, 1'b0);
    host.i2c_start();
    host.i2c_wr(8'h13, a);
    host.i2c_rd(1'b0, d0);
    host.i2c_rd(1'b1, d1);
    host.i2c_stop();
    chk(a, 1'b0);
    chk(d0, pat(16'h0168));
    chk(d1, pat(16'h0169));
    @(negedge clk_sys_i) addr_2b = 1'b0;
  endtask : t_i2c_rd
  task automatic t_i2c_addr();
    i2c_burst('{8'h14}, 1'b1, 1'b1);
    @(negedge clk_sys_i) addr_ovr = 1'b1;
    i2c_burst('{8'h14, 8'h05, 8'hC3}, 1'b0, 1'b1);
    wchk(24'h0105_C3);
  endtask : t_i2c_addr
  task automatic t_spi_1b();
    logic [7:0] r [$];
    @(negedge clk_sys_i) host.scl_o = 1'b0;
    ssi_spi = 1'b1;
    spi_frame('{8'h7C, 8'h80, 8'h00, 8'h00, 8'h00}, 9, r);
    spi_frame('{8'h64, 8'h50}, 9, r);
    wchk(24'h00E4_50);
    dum_en = 1'b1;
    dum_size = 2'h1;
    spi_frame('{8'hA4, 8'h00, 8'h00, 8'h00, 8'h00}, 1, r);
    chk({r[1], r[2], r[3], r[4]}, {16'h0, pat(16'h00A4), pat(16'h00A5)});
    chk(wq.size(), 0);
  endtask : t_spi_1b
  task automatic t_spi_2b();
    logic [7:0] r [$];
    @(negedge clk_sys_i) addr_2b = 1'b1;
    dum_size = 2'h0;
    spi_frame('{8'h01, 8'h24, 8'h50}, 9, r);
    wchk(24'h0124_50);
    spi_frame('{8'h80, 8'hE4, 8'h00, 8'h00, 8'h00}, 2, r);
    chk({r[2], r[3], r[4]}, {8'h0, pat(16'h00E4), pat(16'h00E5)});
    // falling-edge sampling with early output, clock idling high
    @(negedge clk_sys_i) host.scl_o = 1'b1;
    clk_sel = 1'b1;
    del_out = 1'b1;
    spi_frame('{8'h81, 8'h68, 8'h00, 8'h00, 8'h00}, 2, r);
    chk({r[2], r[3], r[4]}, {8'h0, pat(16'h0168), pat(16'h0169)});
  endtask : t_spi_2b
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // reset, then the scenarios in order
  initial begin
    {load_done, ssi_spi, addr_2b, addr_ovr, dum_en, clk_sel, del_out} = 7'h00;
    #1 rstn_i = 1'b0;
    i2c_addr = 7'h0A;
    speed = 2'h2;
    dum_size = 2'h0;
    repeat (8) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    t_dead();
    t_i2c_1b();
    t_i2c_rd();
    t_i2c_addr();
    t_spi_1b();
    t_spi_2b();
    final_report();
  end
endmodule : tb_serial_register_access_port
